// >>> tibc_pkg.sv
// tibc_pkg: attribute ids, service codes, answer codes, result bits and counts
// for the teach-in and blanking control object.
// assumes: included as tibc_pkg::name by the design module and the monitor.
package tibc_pkg;

  // attribute service codes
  localparam logic [7:0] SVC_GET = 8'h0E;
  localparam logic [7:0] SVC_SET = 8'h10;

  // attribute ids of the object
  localparam logic [7:0] ATTR_TEACH_START = 8'h01;
  localparam logic [7:0] ATTR_TEACH_RESULT = 8'h02;
  localparam logic [7:0] ATTR_TEACH_NEEDED = 8'h03;
  localparam logic [7:0] ATTR_TEACH_BLANK_EN = 8'h04;
  localparam logic [7:0] ATTR_BLANK_BLOCKED = 8'h05;
  localparam logic [7:0] ATTR_BLANK_MADE = 8'h06;

  // general status codes of the answer
  localparam logic [7:0] STS_OK = 8'h00;
  localparam logic [7:0] STS_SVC_UNSUPPORTED = 8'h08;
  localparam logic [7:0] STS_NOT_SETTABLE = 8'h0E;
  localparam logic [7:0] STS_ATTR_UNSUPPORTED = 8'h14;

  // teach-in result bit positions
  localparam int RES_GENERAL_ERR = 0;
  localparam int RES_PARALLEL_ERR = 1;
  localparam int RES_SIGNAL_LOW = 2;
  localparam int RES_SIGNAL_HIGH = 3;
  localparam int RES_CROSS_ERR = 4;
  localparam int RES_HISPEED_WARN = 5;
  localparam int RES_BLANK_ERR = 6;
  localparam int RES_AUTO_WARN = 7;

  // values after reset
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic TEACH_NEEDED_RESET = 1'b1;

  // teach-in run time in cycles and signal level limits
  localparam int TEACH_CYCLES = 16;
  localparam logic [7:0] LEVEL_MIN = 8'h10;
  localparam logic [7:0] LEVEL_MAX = 8'hF0;

  // teach sequencer
  typedef enum logic [1:0] {
    TIBC_IDLE = 2'b00,
    TIBC_RUN = 2'b01,
    TIBC_DONE = 2'b10
  } tibc_state_t;

endpackage : tibc_pkg

// >>> tibc_scanner.sv
// tibc_scanner: fieldbus controller model issuing get and set services
// assumes: shares clk with the object, one request outstanding at a time
`timescale 1ns/100ps
`default_nettype none
module tibc_scanner (
  // clock
  input wire logic clk,
  // request
  output logic reqValid,
  output logic [7:0] reqService,
  output logic [7:0] reqAttr,
  output logic [7:0] reqData,
  // answer
  input wire logic rspValid,
  input wire logic [7:0] rspStatus,
  input wire logic [7:0] rspData
);
  // idle before the first request
  initial begin
    reqValid = 1'b0;
    reqService = 8'h00;
    reqAttr = 8'h00;
    reqData = 8'h00;
  end
  // one request; command edges are made by the caller writing 0 then 1
  // lines are inverted after use so stale values are never mistaken
  task automatic xfer(input logic [7:0] s, a, d, output logic v, output logic [7:0] st, rd);
    @(posedge clk);
    reqValid <= 1'b1;
    reqService <= s;
    reqAttr <= a;
    reqData <= d;
    @(posedge clk);
    reqValid <= 1'b0;
    reqService <= ~s;
    reqAttr <= ~a;
    reqData <= ~d;
    #1;
    v = rspValid;
    st = rspStatus;
    rd = rspData;
    // end on an edge so the caller's next drive lands on the clock
    @(posedge clk);
  endtask : xfer
  // teach at start, clear area before restore, block beams before blanking
  // are ordered by the caller
endmodule : tibc_scanner
`default_nettype wire

// >>> tibc_teach_blank.sv
// tibc_teach_blank: teach-in and beam blanking object behind get/set services.
// assumes: service requests and the optical front end run on clk; one request
// per cycle at most, answered one cycle later.
//
// Contract
// R1: get service returns addressed attribute value
// R2: set service writes supplied value to attribute
// R3: read-only attributes refuse the set service
// R4: teach command: 0 idle, 1 start
// R5: teach starts only on 0-to-1 edge
// R6: teach sets per-beam switching thresholds
// R7: controller teaches at commissioning and mode changes
// R8: result attribute holds 8-bit last teach outcome
// R9: error bits 0, 1, 4, 6
// R10: warning bits 2, 3, 5, 7
// R11: teach-needed flag reads 1 when required
// R12: blanking enable adds blanking to each teach
// R13: teach blanking excludes blocked or made beams
// R14: restore all beams: clear, blank-blocked, enable, teach
// R15: blank-blocked edge excludes currently blocked beams
// R16: operator blocks exactly the beams to exclude
// R17: blank-made edge excludes currently made beams
// R18: blanking retriggers only after a written 0
// R19: excluded beams ignored in later evaluation
// R20: command attributes read back last written value
`timescale 1ns/100ps
`default_nettype none
module tibc_teach_blank #(
  parameter int BEAMS = 32,
  parameter int TEACH_CYCLES = tibc_pkg::TEACH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // attribute service request
  input wire logic reqValid,
  input wire logic [7:0] reqService,
  input wire logic [7:0] reqAttr,
  input wire logic [7:0] reqData,
  // attribute service answer
  output logic rspValid,
  output logic [7:0] rspStatus,
  output logic [7:0] rspData,
  // optical front end
  input wire logic [BEAMS-1:0] beamBlocked,
  input wire logic [BEAMS*8-1:0] beamLevel,
  input wire logic [7:0] ambientLevel,
  input wire logic parallelFault,
  input wire logic crossFault,
  input wire logic hiSpeedImpossible,
  input wire logic autoTeachImpossible,
  input wire logic configChanged,
  // thresholds, blanking and evaluation
  output logic [BEAMS*8-1:0] beamThreshold,
  output logic [BEAMS-1:0] beamIncluded,
  output logic [BEAMS-1:0] evalBlocked,
  output logic teachBusy
);

  // threshold midway between the taught level and the ambient floor
  function automatic logic [7:0] calc_threshold(input logic [7:0] lvl, input logic [7:0] amb);
    logic [8:0] sum;
    sum = {1'b0, lvl} + {1'b0, amb};
    return sum[8:1];
  endfunction : calc_threshold

  // boolean attribute as an answer byte
  function automatic logic [7:0] bool_word(input logic b);
    return {7'h00, b};
  endfunction : bool_word

  // signal level of one beam out of the packed front-end word
  function automatic logic [7:0] level_of(input logic [BEAMS*8-1:0] lv, input int idx);
    return lv[idx*8 +: 8];
  endfunction : level_of

  // teach-run counter width
  localparam int CW = $clog2(TEACH_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(TEACH_CYCLES - 1);

  // state
  tibc_pkg::tibc_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic teachCmd_ff, blankEn_ff;
  logic blankBlockedCmd_ff, blankMadeCmd_ff;
  logic [7:0] result_ff, nxt_result;
  logic needed_ff, nxt_needed;
  logic [BEAMS-1:0] included_ff, nxt_included;
  logic [BEAMS*8-1:0] thresh_ff, nxt_thresh;
  logic [BEAMS-1:0] evalBlocked_ff;
  logic rspValid_ff;
  logic [7:0] rspStatus_ff, rspData_ff;
  logic [7:0] nxt_rspStatus, nxt_rspData;
  logic busy_ff;

  // attribute map of the object
  //   01 teach command, read/write, acts on a 0-to-1 edge
  //   02 outcome of the last completed run, read only
  //   03 teach needed, read only
  //   04 blanking folded into each run, read/write level
  //   05 blank blocked beams, read/write, acts on a 0-to-1 edge
  //   06 blank made beams, read/write, acts on a 0-to-1 edge
  // a set on 02 or 03 is answered as not settable and changes nothing

  // request decode
  wire isGet = reqValid && (reqService == tibc_pkg::SVC_GET);
  wire isSet = reqValid && (reqService == tibc_pkg::SVC_SET);
  wire attrRw = (reqAttr == tibc_pkg::ATTR_TEACH_START) ||
                (reqAttr == tibc_pkg::ATTR_TEACH_BLANK_EN) ||
                (reqAttr == tibc_pkg::ATTR_BLANK_BLOCKED) ||
                (reqAttr == tibc_pkg::ATTR_BLANK_MADE);
  wire attrRo = (reqAttr == tibc_pkg::ATTR_TEACH_RESULT) ||
                (reqAttr == tibc_pkg::ATTR_TEACH_NEEDED);
  wire setOk = isSet && attrRw; // R2 R3
  wire wrTeach = setOk && (reqAttr == tibc_pkg::ATTR_TEACH_START);
  wire wrBlankEn = setOk && (reqAttr == tibc_pkg::ATTR_TEACH_BLANK_EN);
  wire wrBlocked = setOk && (reqAttr == tibc_pkg::ATTR_BLANK_BLOCKED);
  wire wrMade = setOk && (reqAttr == tibc_pkg::ATTR_BLANK_MADE);
  wire wrBit = reqData[0];

  // command edges: only a written 1 over a stored 0 fires
  // a repeated 1 is stored again but is not an edge
  wire teachEdge = wrTeach && wrBit && !teachCmd_ff; // R4 R5
  wire blockedEdge = wrBlocked && wrBit && !blankBlockedCmd_ff; // R15 R18
  wire madeEdge = wrMade && wrBit && !blankMadeCmd_ff; // R17 R18

  // blanking masks from the live beam picture, 1 = beam stays in evaluation
  wire [BEAMS-1:0] maskBlocked = ~beamBlocked; // R15
  wire [BEAMS-1:0] maskMade = beamBlocked; // R17
  // teach blanking takes made-beam mode when that command is armed
  // made mode with nothing blocked would drop every beam; the run flags that
  wire [BEAMS-1:0] teachMask = blankMadeCmd_ff ? maskMade : maskBlocked; // R13

  // signal level checks over all beams
  // one weak or overdriven beam flags the run; the word does not say which
  logic anyLow, anyHigh;
  always_comb begin
    anyLow = 1'b0;
    anyHigh = 1'b0;
    for (int i = 0; i < BEAMS; i++) begin
      if (level_of(beamLevel, i) < tibc_pkg::LEVEL_MIN) begin
        anyLow = 1'b1;
      end
      if (level_of(beamLevel, i) > tibc_pkg::LEVEL_MAX) begin
        anyHigh = 1'b1;
      end
    end
  end

  // outcome word built at the end of a teach run
  wire blankErr = blankEn_ff && (teachMask == '0);
  logic [7:0] doneWord;
  always_comb begin
    doneWord = 8'h00;
    doneWord[tibc_pkg::RES_PARALLEL_ERR] = parallelFault; // R9
    doneWord[tibc_pkg::RES_CROSS_ERR] = crossFault; // R9
    doneWord[tibc_pkg::RES_BLANK_ERR] = blankErr; // R9
    doneWord[tibc_pkg::RES_GENERAL_ERR] = parallelFault || crossFault || blankErr; // R9
    doneWord[tibc_pkg::RES_SIGNAL_LOW] = anyLow; // R10
    doneWord[tibc_pkg::RES_SIGNAL_HIGH] = anyHigh; // R10
    doneWord[tibc_pkg::RES_HISPEED_WARN] = hiSpeedImpossible; // R10
    doneWord[tibc_pkg::RES_AUTO_WARN] = autoTeachImpossible; // R10
  end
  wire doneErr = doneWord[tibc_pkg::RES_GENERAL_ERR];
  wire teachDone = (state_ff == tibc_pkg::TIBC_DONE);

  // teach sequencer; an edge while a run is busy is stored but starts nothing
  // a run cannot be cut short; a config change during it only sets the flag
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      tibc_pkg::TIBC_IDLE: begin
        nxt_cnt = '0;
        if (teachEdge) begin
          nxt_state = tibc_pkg::TIBC_RUN; // R5
        end
      end
      tibc_pkg::TIBC_RUN: begin
        nxt_cnt = cnt_ff + CW'(1);
        if (cnt_ff == CNT_LAST) begin
          nxt_state = tibc_pkg::TIBC_DONE;
        end
      end
      tibc_pkg::TIBC_DONE: begin
        nxt_state = tibc_pkg::TIBC_IDLE;
      end
      default: begin
        nxt_state = tibc_pkg::TIBC_IDLE;
      end
    endcase
  end

  // thresholds are latched only when a run completes, so a half-taught
  // set never reaches the comparators
  always_comb begin
    nxt_thresh = thresh_ff;
    if (teachDone) begin
      for (int i = 0; i < BEAMS; i++) begin
        nxt_thresh[i*8 +: 8] = calc_threshold(level_of(beamLevel, i), ambientLevel); // R6
      end
    end
  end

  // result word keeps the last completed run
  assign nxt_result = teachDone ? doneWord : result_ff; // R8

  // teach-needed: a config change wins over a clean finish in the same cycle
  // a run that ends in error does not clear the flag; it keeps the value it holds when the run ends
  always_comb begin
    nxt_needed = needed_ff;
    if (teachDone && !doneErr) begin
      nxt_needed = 1'b0; // R11
    end
    if (configChanged) begin
      nxt_needed = 1'b1; // R11
    end
  end

  // blanking mask: manual commands, or blanking folded into a teach run
  always_comb begin
    nxt_included = included_ff;
    if (teachDone && blankEn_ff && !blankErr) begin
      nxt_included = teachMask; // R12 R13 R14
    end
    if (blockedEdge) begin
      nxt_included = maskBlocked; // R15
    end
    if (madeEdge) begin
      nxt_included = maskMade; // R17
    end
  end

  // answer: status and data for the request of this cycle
  always_comb begin
    nxt_rspStatus = tibc_pkg::STS_OK;
    nxt_rspData = 8'h00;
    if (!isGet && !isSet) begin
      nxt_rspStatus = tibc_pkg::STS_SVC_UNSUPPORTED;
    end else if (!attrRw && !attrRo) begin
      nxt_rspStatus = tibc_pkg::STS_ATTR_UNSUPPORTED;
    end else if (isSet && attrRo) begin
      nxt_rspStatus = tibc_pkg::STS_NOT_SETTABLE; // R3
    end else if (isGet) begin
      case (reqAttr)
        tibc_pkg::ATTR_TEACH_START: nxt_rspData = bool_word(teachCmd_ff); // R20
        tibc_pkg::ATTR_TEACH_RESULT: nxt_rspData = result_ff; // R1 R8
        tibc_pkg::ATTR_TEACH_NEEDED: nxt_rspData = bool_word(needed_ff); // R1 R11
        tibc_pkg::ATTR_TEACH_BLANK_EN: nxt_rspData = bool_word(blankEn_ff); // R1
        tibc_pkg::ATTR_BLANK_BLOCKED: nxt_rspData = bool_word(blankBlockedCmd_ff); // R20
        tibc_pkg::ATTR_BLANK_MADE: nxt_rspData = bool_word(blankMadeCmd_ff); // R20
        default: nxt_rspData = 8'h00;
      endcase
    end
  end

  // sequencer and run counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= tibc_pkg::TIBC_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // busy flag kept in its own flop so the output needs no decode; it
  // follows the state register cycle for cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state == tibc_pkg::TIBC_RUN);
    end
  end

  // command attributes hold what was last written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      teachCmd_ff <= 1'b0;
      blankEn_ff <= 1'b0;
      blankBlockedCmd_ff <= 1'b0;
      blankMadeCmd_ff <= 1'b0;
    end else begin
      teachCmd_ff <= wrTeach ? wrBit : teachCmd_ff; // R2 R20
      blankEn_ff <= wrBlankEn ? wrBit : blankEn_ff; // R2 R12
      blankBlockedCmd_ff <= wrBlocked ? wrBit : blankBlockedCmd_ff; // R2 R20
      blankMadeCmd_ff <= wrMade ? wrBit : blankMadeCmd_ff; // R2 R20
    end
  end

  // teach outcome, thresholds and blanking mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_ff <= tibc_pkg::RESULT_RESET;
      needed_ff <= tibc_pkg::TEACH_NEEDED_RESET;
      included_ff <= '1;
      thresh_ff <= '0;
    end else begin
      result_ff <= nxt_result;
      needed_ff <= nxt_needed;
      included_ff <= nxt_included;
      thresh_ff <= nxt_thresh;
    end
  end

  // evaluation drops excluded beams; one cycle behind the front end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evalBlocked_ff <= '0;
    end else begin
      evalBlocked_ff <= beamBlocked & included_ff; // R19
    end
  end

  // answer registers
  // status and data hold between answers so a late reader still finds them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rspValid_ff <= 1'b0;
      rspStatus_ff <= tibc_pkg::STS_OK;
      rspData_ff <= 8'h00;
    end else begin
      rspValid_ff <= reqValid;
      rspStatus_ff <= reqValid ? nxt_rspStatus : rspStatus_ff;
      rspData_ff <= reqValid ? nxt_rspData : rspData_ff;
    end
  end

  // outputs straight from flip-flops
  // thresholds read zero until the first run completes
  assign rspValid = rspValid_ff;
  assign rspStatus = rspStatus_ff;
  assign rspData = rspData_ff;
  assign beamThreshold = thresh_ff;
  assign beamIncluded = included_ff;
  assign evalBlocked = evalBlocked_ff;
  assign teachBusy = busy_ff;

endmodule : tibc_teach_blank
`default_nettype wire

// >>> tibc_teach_blank_monitor.sv
// checker for the service port, teach sequencer and beam mask
// assumes: bound into tibc_teach_blank, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module tibc_teach_blank_monitor #(
  parameter int BEAMS = 32,
  parameter int TEACH_CYCLES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // service port
  input wire logic reqValid,
  input wire logic [7:0] reqService,
  input wire logic [7:0] reqAttr,
  input wire logic [7:0] reqData,
  input wire logic rspValid,
  input wire logic [7:0] rspStatus,
  // beams
  input wire logic [BEAMS-1:0] beamBlocked,
  input wire logic [BEAMS-1:0] beamIncluded,
  input wire logic [BEAMS-1:0] evalBlocked,
  input wire logic teachBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] busyCnt_ff;
  logic blkCmd_ff;
  // request decode
  wire isGet = reqValid && reqService == tibc_pkg::SVC_GET;
  wire isSet = reqValid && reqService == tibc_pkg::SVC_SET;
  wire known = reqAttr >= 8'h01 && reqAttr <= 8'h06;
  // busy length counter; counts busy cycles, holds the run length for one cycle after a run, zero while idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busyCnt_ff <= 16'h0000;
    else busyCnt_ff <= teachBusy ? busyCnt_ff + 16'h0001 : 16'h0000;
  end
  // stored blank-blocked command as seen on the service port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) blkCmd_ff <= 1'b0;
    else if (isSet && reqAttr == 8'h05) blkCmd_ff <= reqData[0];
  end
  a_answer_next: assert property (reqValid |=> rspValid)
    else $error("no answer one cycle after request");
  a_no_spurious: assert property (!reqValid |=> !rspValid)
    else $error("answer without request");
  a_get_ok: assert property (isGet && known |=> rspStatus == tibc_pkg::STS_OK)
    else $error("get of known attribute not ok");
  a_ro_refused: assert property (isSet && (reqAttr == 8'h02 || reqAttr == 8'h03)
    |=> rspStatus == tibc_pkg::STS_NOT_SETTABLE) else $error("set on read-only taken");
  a_bad_service: assert property (reqValid && !isGet && !isSet
    |=> rspStatus == tibc_pkg::STS_SVC_UNSUPPORTED) else $error("unknown service taken");
  a_teach_cause: assert property ($rose(teachBusy)
    |-> $past(isSet && reqAttr == 8'h01 && reqData[0])) else $error("teach without command");
  a_teach_length: assert property ($fell(teachBusy) && !$past(rst)
    |-> busyCnt_ff == TEACH_CYCLES) else $error("teach run length wrong");
  a_eval_lag: assert property (!rst |=> evalBlocked == $past(beamBlocked & beamIncluded))
    else $error("evaluation ignores mask");
  a_blank_blocked: assert property (isSet && reqAttr == 8'h05 && reqData[0] && !blkCmd_ff
    |=> beamIncluded == ~$past(beamBlocked))
    else $error("blank blocked mask wrong");
  c_teach: cover property ($fell(teachBusy));
  c_refused: cover property (rspValid && rspStatus == tibc_pkg::STS_NOT_SETTABLE);
  c_blank: cover property (isSet && reqAttr == 8'h06 && reqData[0]);
endmodule : tibc_teach_blank_monitor
`default_nettype wire

// >>> tibc_teach_blank_tb.sv
// testbench for tibc_teach_blank with a controller model and bound checker
// assumes: tibc_pkg, tibc_scanner and the monitor compiled before
`timescale 1ns/100ps
`default_nettype none
module tibc_teach_blank_tb;
  localparam int NB = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid, rspValid, teachBusy;
  logic [7:0] reqService, reqAttr, reqData, rspStatus, rspData;
  logic [NB-1:0] beamBlocked = 8'h00;
  logic [NB*8-1:0] beamLevel = {NB{8'h80}};
  logic [7:0] ambientLevel = 8'h20;
  logic [3:0] flt = 4'h0;
  logic configChanged = 1'b0;
  logic [NB*8-1:0] beamThreshold;
  logic [NB-1:0] beamIncluded, evalBlocked;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  tibc_teach_blank #(.BEAMS(NB), .TEACH_CYCLES(4)) uut (.clk(clk), .rst(rst),
    .reqValid(reqValid), .reqService(reqService), .reqAttr(reqAttr), .reqData(reqData),
    .rspValid(rspValid), .rspStatus(rspStatus), .rspData(rspData),
    .beamBlocked(beamBlocked), .beamLevel(beamLevel), .ambientLevel(ambientLevel),
    .parallelFault(flt[0]), .crossFault(flt[1]), .hiSpeedImpossible(flt[2]),
    .autoTeachImpossible(flt[3]), .configChanged(configChanged),
    .beamThreshold(beamThreshold), .beamIncluded(beamIncluded),
    .evalBlocked(evalBlocked), .teachBusy(teachBusy));
  tibc_scanner sc (.clk(clk), .reqValid(reqValid), .reqService(reqService),
    .reqAttr(reqAttr), .reqData(reqData), .rspValid(rspValid),
    .rspStatus(rspStatus), .rspData(rspData));
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [63:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk
  // one service with its answer judged
  task automatic svc(input logic [7:0] s, a, d, es, ed);
    logic v;
    logic [7:0] st, rd;
    sc.xfer(s, a, d, v, st, rd);
    chk("rspValid", 64'h1, {63'h0, v});
    chk("rspStatus", {56'h0, es}, {56'h0, st});
    chk("rspData", {56'h0, ed}, {56'h0, rd});
  endtask : svc
  // write 1 to the teach command and wait out any run
  task automatic teach(input logic started);
    int n;
    n = 0;
    svc(8'h10, 8'h01, 8'h01, 8'h00, 8'h00);
    chk("teachBusy", {63'h0, started}, {63'h0, teachBusy});
    while (teachBusy === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask : teach
  task automatic t_access();
    logic [7:0] rv [1:6];
    rv = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    for (int i = 1; i <= 6; i++) svc(8'h0E, 8'(i), 8'h00, 8'h00, rv[i]);
    svc(8'h10, 8'h02, 8'hFF, 8'h0E, 8'h00);
    svc(8'h10, 8'h03, 8'h00, 8'h0E, 8'h00);
    svc(8'h0E, 8'h03, 8'h00, 8'h00, 8'h01);
    svc(8'h0E, 8'h07, 8'h00, 8'h14, 8'h00);
    svc(8'h01, 8'h01, 8'h00, 8'h08, 8'h00);
    svc(8'h10, 8'h04, 8'h01, 8'h00, 8'h00);
    svc(8'h0E, 8'h04, 8'h00, 8'h00, 8'h01);
    svc(8'h10, 8'h04, 8'h00, 8'h00, 8'h00);
  endtask : t_access
  task automatic t_teach();
    @(posedge clk);
    beamLevel <= {{4{8'h80}}, 8'h05, {3{8'h80}}};
    flt <= 4'h5;
    teach(1'b1);
    chk("beamThreshold", {{4{8'h50}}, 8'h12, {3{8'h50}}}, beamThreshold);
    svc(8'h0E, 8'h02, 8'h00, 8'h00, 8'h27);
    svc(8'h0E, 8'h03, 8'h00, 8'h00, 8'h01);
    svc(8'h0E, 8'h01, 8'h00, 8'h00, 8'h01);
    teach(1'b0);
    beamLevel <= {NB{8'h80}};
    flt <= 4'hA;
    svc(8'h10, 8'h01, 8'h00, 8'h00, 8'h00);
    teach(1'b1);
    svc(8'h0E, 8'h02, 8'h00, 8'h00, 8'h91);
    svc(8'h10, 8'h01, 8'h00, 8'h00, 8'h00);
    flt <= 4'h0;
    teach(1'b1);
    svc(8'h0E, 8'h02, 8'h00, 8'h00, 8'h00);
    svc(8'h0E, 8'h03, 8'h00, 8'h00, 8'h00);
    configChanged <= 1'b1;
    @(posedge clk);
    configChanged <= 1'b0;
    svc(8'h0E, 8'h03, 8'h00, 8'h00, 8'h01);
    svc(8'h10, 8'h01, 8'h00, 8'h00, 8'h00);
    teach(1'b1);
    svc(8'h0E, 8'h03, 8'h00, 8'h00, 8'h00);
    svc(8'h10, 8'h01, 8'h00, 8'h00, 8'h00);
  endtask : t_teach
  task automatic t_blank();
    beamBlocked <= 8'h3C;
    svc(8'h10, 8'h05, 8'h01, 8'h00, 8'h00);
    chk("beamIncluded", 64'hC3, {56'h0, beamIncluded});
    beamBlocked <= 8'hFF;
    repeat (2) @(posedge clk);
    #1 chk("evalBlocked", 64'hC3, {56'h0, evalBlocked});
    svc(8'h10, 8'h05, 8'h01, 8'h00, 8'h00);
    chk("beamIncluded", 64'hC3, {56'h0, beamIncluded});
    svc(8'h10, 8'h05, 8'h00, 8'h00, 8'h00);
    beamBlocked <= 8'h0F;
    svc(8'h10, 8'h06, 8'h01, 8'h00, 8'h00);
    chk("beamIncluded", 64'h0F, {56'h0, beamIncluded});
    beamBlocked <= 8'h55;
    svc(8'h10, 8'h04, 8'h01, 8'h00, 8'h00);
    teach(1'b1);
    chk("beamIncluded", 64'h55, {56'h0, beamIncluded});
    svc(8'h10, 8'h01, 8'h00, 8'h00, 8'h00);
    beamBlocked <= 8'h00;
    teach(1'b1);
    svc(8'h0E, 8'h02, 8'h00, 8'h00, 8'h41);
    chk("beamIncluded", 64'h55, {56'h0, beamIncluded});
    svc(8'h10, 8'h01, 8'h00, 8'h00, 8'h00);
    svc(8'h10, 8'h06, 8'h00, 8'h00, 8'h00);
    svc(8'h10, 8'h05, 8'h01, 8'h00, 8'h00);
    teach(1'b1);
    chk("beamIncluded", 64'hFF, {56'h0, beamIncluded});
  endtask : t_blank
  // a hang ends as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_access();
    t_teach();
    t_blank();
    report_and_stop();
  end
endmodule : tibc_teach_blank_tb
bind tibc_teach_blank tibc_teach_blank_monitor #(.BEAMS(BEAMS), .TEACH_CYCLES(TEACH_CYCLES)) mon (
  .clk(clk), .rst(rst), .reqValid(reqValid), .reqService(reqService), .reqAttr(reqAttr),
  .reqData(reqData), .rspValid(rspValid), .rspStatus(rspStatus), .beamBlocked(beamBlocked),
  .beamIncluded(beamIncluded), .evalBlocked(evalBlocked), .teachBusy(teachBusy));
`default_nettype wire
